// ===== shared/cru_pkg.sv
package cru_pkg;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int REAL_W = 32;
  localparam logic RESULT_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [REAL_W-1:0] QOUT_RST = 32'h0000_0000;
  localparam int EXP_LSB = 23;
  localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
  // 180/pi and pi/180, single precision
  localparam logic [REAL_W-1:0] RAD_TO_DEG = 32'h4265_2EE1;
  localparam logic [REAL_W-1:0] DEG_TO_RAD = 32'h3C8E_FA35;

  typedef enum logic [2:0] {
    REL_EQ = 3'b000,
    REL_NE = 3'b001,
    REL_GT = 3'b010,
    REL_GE = 3'b011,
    REL_LT = 3'b100,
    at_most_compare = 3'b101
  } relation_e;

  typedef enum logic [1:0] {
    TYPE_INT = 2'b00,
    double_signed_word = 2'b01,
    TYPE_REAL = 2'b10,
    TYPE_WORD = 2'b11
  } data_type_e;

  typedef struct packed {
    logic enable;
    logic to_degrees;
    logic [REAL_W-1:0] value;
  } convert_req_s;

  typedef struct packed {
    logic enable;
    relation_e relation;
    data_type_e dtype;
    logic [DWORD_W-1:0] first_operand;
    logic [DWORD_W-1:0] second_operand;
  } compare_req_s;

  typedef struct packed {
    logic enable;
    data_type_e dtype;
    logic [DWORD_W-1:0] test_value;
    logic [DWORD_W-1:0] bound_a;
    logic [DWORD_W-1:0] bound_b;
  } range_req_s;
endpackage : cru_pkg

// ===== hw/compare_range_convert_unit.sv
module compare_range_convert_unit (
  input wire logic clk,
  input wire logic reset,
  input cru_pkg::convert_req_s conv_req,
  input cru_pkg::compare_req_s cmp_req,
  input cru_pkg::range_req_s rng_req,
  output logic [cru_pkg::REAL_W-1:0] conv_result,
  output logic conv_ok,
  output logic cmp_result,
  output logic range_result,
  output logic float_compare_valid_flag
);
  import cru_pkg::*;

  // Single-precision multiply, truncating; no denormals, overflow saturates to inf
  function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] prod;
    logic [9:0] ex;
    logic [22:0] man;
    logic sgn;
    prod = 48'h0000_0000_0000;
    ex = 10'h000;
    man = 23'h00_0000;
    sgn = a[31] ^ b[31];
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
    begin
      fmul = {sgn, 31'h0000_0000};
    end
    else if (a[30:23] == EXP_ALL_ONES)
    begin
      fmul = {sgn, a[30:0]};
    end
    else
    begin
      prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      ex = 10'({2'b00, a[30:23]}) + 10'({2'b00, b[30:23]}) - 10'h07F;
      if (prod[47])
      begin
        man = prod[46:24];
        ex = ex + 10'h001;
      end
      else
      begin
        man = prod[45:23];
      end
      if (ex[9] || ex == 10'h000)
        fmul = {sgn, 31'h0000_0000};
      else if (ex[8] || ex[7:0] == EXP_ALL_ONES)
        fmul = {sgn, EXP_ALL_ONES, 23'h00_0000};
      else
        fmul = {sgn, ex[7:0], man};
    end
  endfunction : fmul

  // Map float bits to an order-preserving unsigned key
  function automatic logic [31:0] fkey(input logic [31:0] f);
    fkey = f[31] ? ~f : {1'b1, f[30:0]};
  endfunction : fkey

  // Conversion path
  wire conv_nan = (conv_req.value[30:23] == EXP_ALL_ONES) && (conv_req.value[22:0] != 23'h0);
  wire [31:0] conv_factor = conv_req.to_degrees ? RAD_TO_DEG : DEG_TO_RAD;
  wire [31:0] conv_prod = fmul(conv_req.value, conv_factor);

  logic [REAL_W-1:0] conv_result_q;
  logic conv_ok_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      conv_result_q <= QOUT_RST;
    else if (conv_req.enable)
      conv_result_q <= conv_prod;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      conv_ok_q <= RESULT_RST;
    else
      conv_ok_q <= conv_req.enable && !conv_nan;
  end

  // operand typing; first is always left term
  wire is_real = (cmp_req.dtype == TYPE_REAL);
  wire [31:0] a_int = {{16{cmp_req.first_operand[15]}}, cmp_req.first_operand[15:0]};
  wire [31:0] b_int = {{16{cmp_req.second_operand[15]}}, cmp_req.second_operand[15:0]};
  wire a_nan = (cmp_req.first_operand[30:23] == EXP_ALL_ONES)
    && (cmp_req.first_operand[22:0] != 23'h0);
  wire b_nan = (cmp_req.second_operand[30:23] == EXP_ALL_ONES)
    && (cmp_req.second_operand[22:0] != 23'h0);
  wire any_nan = is_real && (a_nan || b_nan);
  // Signed-zero pair compares equal
  wire both_zero = (cmp_req.first_operand[30:0] == 31'h0)
    && (cmp_req.second_operand[30:0] == 31'h0);
  wire [31:0] lhs_s = (cmp_req.dtype == TYPE_INT) ? a_int : cmp_req.first_operand;
  wire [31:0] rhs_s = (cmp_req.dtype == TYPE_INT) ? b_int : cmp_req.second_operand;
  wire int_eq = (lhs_s == rhs_s);
  wire int_lt = $signed(lhs_s) < $signed(rhs_s);
  wire real_eq = both_zero || (cmp_req.first_operand == cmp_req.second_operand);
  wire real_lt = !both_zero && (fkey(cmp_req.first_operand) < fkey(cmp_req.second_operand));
  wire rel_eq = is_real ? real_eq : int_eq;
  wire rel_lt = is_real ? real_lt : int_lt;

  logic rel_true;
  always_comb
  begin
    case (cmp_req.relation)
      REL_EQ: rel_true = rel_eq;
      REL_NE: rel_true = !rel_eq;
      REL_GT: rel_true = !rel_eq && !rel_lt;
      REL_GE: rel_true = !rel_lt;
      REL_LT: rel_true = rel_lt;
      at_most_compare: rel_true = rel_lt || rel_eq;
      default: rel_true = 1'b0;
    endcase
  end

  logic cmp_result_q;
  logic flag_q;

  // result or zero when idle; NaN never satisfies
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cmp_result_q <= RESULT_RST;
    else
      cmp_result_q <= cmp_req.enable && !any_nan && rel_true;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flag_q <= FLAG_RST;
    else if (cmp_req.enable && is_real)
      flag_q <= !any_nan;
  end

  // 33 bits let unsigned word and signed double share one signed compare
  // operand widening; word is unsigned, others signed
  function automatic logic [32:0] widen(input data_type_e t, input logic [31:0] v);
    case (t)
      TYPE_WORD: widen = {17'h0_0000, v[15:0]};
      double_signed_word: widen = {v[31], v};
      default: widen = {{17{v[15]}}, v[15:0]};
    endcase
  endfunction : widen

  wire [32:0] rv = widen(rng_req.dtype, rng_req.test_value);
  wire [32:0] ra = widen(rng_req.dtype, rng_req.bound_a);
  wire [32:0] rb = widen(rng_req.dtype, rng_req.bound_b);
  wire a_low = $signed(ra) <= $signed(rb);
  wire [32:0] lo = a_low ? ra : rb;
  wire [32:0] hi = a_low ? rb : ra;
  wire in_range = ($signed(rv) >= $signed(lo)) && ($signed(rv) <= $signed(hi));

  logic range_result_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      range_result_q <= RESULT_RST;
    else
      range_result_q <= rng_req.enable && in_range;
  end

  assign conv_result = conv_result_q;
  assign conv_ok = conv_ok_q;
  assign cmp_result = cmp_result_q;
  assign range_result = range_result_q;
  assign float_compare_valid_flag = flag_q;

  chk_conv_ok_nan: assert property (@(posedge clk) disable iff (reset)
    conv_req.enable && conv_nan |=> !conv_ok)
    else $error("conversion ok raised on NaN input");
  chk_conv_ok_set: assert property (@(posedge clk) disable iff (reset)
    conv_req.enable && !conv_nan |=> conv_ok)
    else $error("conversion ok missing");
  chk_conv_hold: assert property (@(posedge clk) disable iff (reset)
    !conv_req.enable |=> $stable(conv_result) && !conv_ok)
    else $error("conversion acted while disabled");
  chk_conv_value: assert property (@(posedge clk) disable iff (reset)
    conv_req.enable |=> conv_result == $past(conv_prod))
    else $error("conversion result not loaded");
  chk_cmp_idle: assert property (@(posedge clk) disable iff (reset)
    !cmp_req.enable |=> !cmp_result)
    else $error("compare result high while disabled");
  chk_int_lt: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.dtype == TYPE_INT && cmp_req.relation == REL_LT
    |=> cmp_result == ($signed($past(cmp_req.first_operand[15:0]))
      < $signed($past(cmp_req.second_operand[15:0]))))
    else $error("int less-than wrong orientation");
  chk_eq_ne: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && !is_real && cmp_req.relation == REL_NE
    |=> cmp_result != ($past(lhs_s) == $past(rhs_s)))
    else $error("not-equal result wrong");
  chk_flag_nan: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && any_nan |=> !float_compare_valid_flag)
    else $error("float flag not cleared on NaN");
  chk_flag_hold: assert property (@(posedge clk) disable iff (reset)
    !(cmp_req.enable && is_real) |=> $stable(float_compare_valid_flag))
    else $error("float flag changed without real compare");
  chk_range_sym: assert property (@(posedge clk) disable iff (reset)
    rng_req.enable && rng_req.test_value == rng_req.bound_a |=> range_result)
    else $error("endpoint not inside range");
  chk_range_idle: assert property (@(posedge clk) disable iff (reset)
    !rng_req.enable |=> !range_result)
    else $error("range result high while disabled");

  // Raw-operand checks, independent of the typing muxes
  chk_flag_set: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && is_real && !any_nan |=> float_compare_valid_flag)
    else $error("float flag not set on real compare");

  chk_nan_no_pass: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && any_nan |=> !cmp_result)
    else $error("compare passed flow with NaN operand");

  chk_double_signed_word_gt: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.dtype == double_signed_word && cmp_req.relation == REL_GT
    |=> cmp_result == ($signed($past(cmp_req.first_operand))
      > $signed($past(cmp_req.second_operand))))
    else $error("double greater-than wrong");

  chk_double_signed_word_ge: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.dtype == double_signed_word && cmp_req.relation == REL_GE
    |=> cmp_result == ($signed($past(cmp_req.first_operand))
      >= $signed($past(cmp_req.second_operand))))
    else $error("double greater-or-equal wrong");

  chk_double_signed_word_eq: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.dtype == double_signed_word && cmp_req.relation == REL_EQ
    |=> cmp_result == ($past(cmp_req.first_operand)
      == $past(cmp_req.second_operand)))
    else $error("double equal wrong");

  chk_double_signed_word_le: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.dtype == double_signed_word && cmp_req.relation == at_most_compare
    |=> cmp_result == ($signed($past(cmp_req.first_operand))
      <= $signed($past(cmp_req.second_operand))))
    else $error("double at-most wrong orientation");

  chk_int_ge: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.dtype == TYPE_INT && cmp_req.relation == REL_GE
    |=> cmp_result == ($signed($past(cmp_req.first_operand[15:0]))
      >= $signed($past(cmp_req.second_operand[15:0]))))
    else $error("int greater-or-equal wrong orientation");

  chk_real_zero_eq: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && is_real && cmp_req.relation == REL_EQ
    && cmp_req.first_operand[30:0] == 31'h0000_0000
    && cmp_req.second_operand[30:0] == 31'h0000_0000 |=> cmp_result)
    else $error("signed zeros not equal");

  chk_rel_unused: assert property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.relation > at_most_compare |=> !cmp_result)
    else $error("undefined relation passed flow");

  chk_range_swap: assert property (@(posedge clk) disable iff (reset)
    rng_req.enable && rng_req.test_value == rng_req.bound_b |=> range_result)
    else $error("second bound not inside range");

  chk_range_below: assert property (@(posedge clk) disable iff (reset)
    rng_req.enable && rng_req.dtype == TYPE_INT
    && $signed(rng_req.test_value[15:0]) < $signed(rng_req.bound_a[15:0])
    && $signed(rng_req.test_value[15:0]) < $signed(rng_req.bound_b[15:0]) |=> !range_result)
    else $error("value below both bounds reported inside");

  chk_word_above: assert property (@(posedge clk) disable iff (reset)
    rng_req.enable && rng_req.dtype == TYPE_WORD
    && rng_req.test_value[15:0] > rng_req.bound_a[15:0]
    && rng_req.test_value[15:0] > rng_req.bound_b[15:0] |=> !range_result)
    else $error("word above both bounds reported inside");

  chk_double_signed_word_inside: assert property (@(posedge clk) disable iff (reset)
    rng_req.enable && rng_req.dtype == double_signed_word
    |=> range_result == (($signed($past(rng_req.test_value)) >= $signed($past(rng_req.bound_a))
      && $signed($past(rng_req.test_value)) <= $signed($past(rng_req.bound_b)))
      || ($signed($past(rng_req.test_value)) >= $signed($past(rng_req.bound_b))
      && $signed($past(rng_req.test_value)) <= $signed($past(rng_req.bound_a)))))
    else $error("double range result wrong");

  chk_conv_nan_out: assert property (@(posedge clk) disable iff (reset)
    conv_req.enable && conv_nan
    |=> conv_result[30:23] == EXP_ALL_ONES && conv_result[22:0] != 23'h00_0000)
    else $error("NaN input did not give NaN result");

  cov_flag_set: cover property (@(posedge clk) disable iff (reset)
    cmp_req.enable && is_real ##1 float_compare_valid_flag);
  cov_real_nan: cover property (@(posedge clk) disable iff (reset)
    cmp_req.enable && any_nan);
  cov_range_hit: cover property (@(posedge clk) disable iff (reset) range_result);
  cov_conv_ok: cover property (@(posedge clk) disable iff (reset) conv_ok);
  cov_le_true: cover property (@(posedge clk) disable iff (reset)
    cmp_req.enable && cmp_req.relation == at_most_compare ##1 cmp_result);
endmodule : compare_range_convert_unit

// ===== dv/operand_store.sv
module operand_store (
  input cru_pkg::convert_req_s conv_in,
  input cru_pkg::compare_req_s cmp_in,
  input cru_pkg::range_req_s rng_in,
  output cru_pkg::convert_req_s conv_out,
  output cru_pkg::compare_req_s cmp_out,
  output cru_pkg::range_req_s rng_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import cru_pkg::*;
  // idle operands scrambled
  // Idle operands are junk, never the last value
  assign conv_out = conv_in.enable ? conv_in : {1'b0, ~conv_in[$bits(conv_in)-2:0]};
  assign cmp_out = cmp_in.enable ? cmp_in : {1'b0, ~cmp_in[$bits(cmp_in)-2:0]};
  assign rng_out = rng_in.enable ? rng_in : {1'b0, ~rng_in[$bits(rng_in)-2:0]};
endmodule : operand_store

// ===== dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cru_pkg::*;
  logic clk;
  logic reset;
  convert_req_s cv;
  compare_req_s cp;
  range_req_s rg;
  convert_req_s cv_w;
  compare_req_s cp_w;
  range_req_s rg_w;
  logic [REAL_W-1:0] conv_result;
  logic conv_ok;
  logic cmp_result;
  logic range_result;
  logic flag;
  int error_cnt;
  int num_checks;
  localparam logic [31:0] ONE = 32'h3F80_0000;
  localparam logic [31:0] NAN = 32'h7FC0_0000;

  always #4 clk = ~clk;

  operand_store operand_store_inst (.conv_in(cv), .cmp_in(cp), .rng_in(rg),
    .conv_out(cv_w), .cmp_out(cp_w), .rng_out(rg_w));

  compare_range_convert_unit compare_range_convert_unit_inst (.clk(clk), .reset(reset),
    .conv_req(cv_w), .cmp_req(cp_w), .rng_req(rg_w), .conv_result(conv_result),
    .conv_ok(conv_ok), .cmp_result(cmp_result), .range_result(range_result),
    .float_compare_valid_flag(flag));

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic rel_exp(input int r, input longint a, input longint b);
    case (r)
      0: return a == b;
      1: return a != b;
      2: return a > b;
      3: return a >= b;
      4: return a < b;
      5: return a <= b;
      default: return 1'b0;
    endcase
  endfunction : rel_exp

  task automatic t_convert;
    cv = '{1'b1, 1'b1, ONE};
    tick();
    chk(conv_result, RAD_TO_DEG);
    chk(conv_ok, 1);
    cv.to_degrees = 1'b0;
    tick();
    chk(conv_result, DEG_TO_RAD);
    cv.enable = 1'b0;
    tick();
    chk(conv_ok, 0);
    chk(conv_result, DEG_TO_RAD);
    cv = '{1'b1, 1'b1, NAN};
    tick();
    chk(conv_ok, 0);
    cv = '{1'b1, 1'b0, 32'h4000_0000};
    tick();
    chk(conv_result, 32'h3D0E_FA35);
    chk(conv_ok, 1);
    cv.enable = 1'b0;
  endtask : t_convert

  task automatic cmp_do(input data_type_e dt, input logic [31:0] a, input logic [31:0] b);
    longint x;
    longint y;
    x = (dt == TYPE_INT) ? longint'($signed(a[15:0])) : longint'($signed(a));
    y = (dt == TYPE_INT) ? longint'($signed(b[15:0])) : longint'($signed(b));
    for (int r = 0; r < 6; r++)
    begin
      cp = '{1'b1, relation_e'(r), dt, a, b};
      tick();
      chk(cmp_result, rel_exp(r, x, y));
    end
  endtask : cmp_do

  task automatic t_compare;
    // Upper half garbage must not matter for the short type
    cmp_do(TYPE_INT, 32'h1234_FFFF, 32'h0000_0001);
    cmp_do(TYPE_INT, 32'h0000_0001, 32'h5678_FFFF);
    cmp_do(TYPE_INT, 32'h0000_0007, 32'hABCD_0007);
    cmp_do(double_signed_word, 32'h8000_0000, 32'h0000_0001);
    chk(flag, 0);
    cp = '{1'b1, REL_LT, TYPE_REAL, ONE, 32'h4000_0000};
    tick();
    chk(cmp_result, 1);
    chk(flag, 1);
    cp.enable = 1'b0;
    tick();
    chk(cmp_result, 0);
    chk(flag, 1);
    cp = '{1'b1, REL_NE, TYPE_REAL, ONE, NAN};
    tick();
    chk(cmp_result, 0);
    chk(flag, 0);
    cp = '{1'b1, REL_EQ, TYPE_REAL, 32'h0000_0000, 32'h8000_0000};
    tick();
    chk(cmp_result, 1);
    chk(flag, 1);
    cp = '{1'b1, REL_GT, TYPE_REAL, 32'hBF80_0000, 32'hC000_0000};
    tick();
    chk(cmp_result, 1);
    cp.relation = REL_LT;
    tick();
    chk(cmp_result, 0);
    cp = '{1'b1, relation_e'(3'h6), TYPE_INT, 32'h0000_0001, 32'h0000_0001};
    tick();
    chk(cmp_result, 0);
    cp.enable = 1'b0;
  endtask : t_compare

  task automatic t_reset;
    cp = '{1'b1, REL_LT, TYPE_REAL, ONE, 32'h4000_0000};
    tick();
    chk(flag, 1);
    reset = 1'b1;
    tick();
    chk(flag, FLAG_RST);
    chk(cmp_result, RESULT_RST);
    chk(conv_result, QOUT_RST);
    reset = 1'b0;
    tick();
    chk(cmp_result, 1);
    chk(flag, 1);
    cp.enable = 1'b0;
  endtask : t_reset

  task automatic rng_do(input data_type_e dt, input logic [31:0] t, input logic [31:0] a,
    input logic [31:0] b, input logic e);
    rg = '{1'b1, dt, t, a, b};
    tick();
    chk(range_result, e);
    rg = '{1'b1, dt, t, b, a};
    tick();
    chk(range_result, e);
  endtask : rng_do

  task automatic t_range;
    rng_do(TYPE_INT, 32'd0, 32'd100, 32'd0, 1'b1);
    rng_do(TYPE_INT, 32'd100, 32'd100, 32'd0, 1'b1);
    rng_do(TYPE_INT, 32'd101, 32'd100, 32'd0, 1'b0);
    rng_do(TYPE_INT, 32'h0000_FFFF, 32'd100, 32'd0, 1'b0);
    // Unsigned view differs from signed for these
    rng_do(TYPE_WORD, 32'h0000_FFFF, 32'd0, 32'h0000_8000, 1'b0);
    rng_do(TYPE_WORD, 32'h0000_7FFF, 32'd0, 32'h0000_8000, 1'b1);
    rng_do(double_signed_word, 32'h0000_8000, 32'd0, 32'h0001_0000, 1'b1);
    rg.enable = 1'b0;
    tick();
    chk(range_result, 0);
  endtask : t_range

  task automatic wrap_up;
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    cv = '0;
    cp = '0;
    rg = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    chk(cmp_result, RESULT_RST);
    chk(conv_result, QOUT_RST);
    t_convert();
    t_compare();
    t_range();
    t_reset();
    wrap_up();
  end
endmodule : tb
